// ### rtl/ppm_pkg.sv
// Package for the profile position mode block: register map, field positions, reset values.
// Assumes a parameter port that carries one word per write or read, addressed by parameter address.
package ppm_pkg;
	localparam logic [15:0] PPM_ADDR_TARGET_POSITION = 16'h1B1C;
	localparam logic [15:0] PPM_ADDR_TARGET_VELOCITY = 16'h1B1E;
	localparam logic [15:0] PPM_ADDR_REL_REF_OPTION  = 16'h1B30;
	localparam logic [15:0] PPM_ADDR_MODE_SELECT     = 16'h1B40;
	localparam logic [15:0] PPM_ADDR_VEL_LIMIT_CTRL  = 16'h1B42;
	localparam logic [15:0] PPM_ADDR_VEL_LIMIT_RAMP  = 16'h1B44;
	localparam logic [15:0] PPM_ADDR_ACCEL           = 16'h1B46;
	localparam logic [15:0] PPM_ADDR_DECEL           = 16'h1B48;
	localparam logic [7:0]  PPM_MODE_PROFILE_POS     = 8'h01;
	localparam logic [31:0] PPM_TARGET_VEL_RESET     = 32'h0000003C;
	localparam logic [31:0] PPM_TARGET_VEL_MIN       = 32'h00000001;
	localparam logic [31:0] PPM_VEL_LIMIT_RESET      = 32'hFFFFFFFF;
	localparam logic [31:0] PPM_ACCEL_RESET          = 32'h00000258;
	localparam logic [15:0] PPM_OPT_PREV_TARGET      = 16'h0000;
	localparam logic [15:0] PPM_OPT_UNSUPPORTED      = 16'h0001;
	localparam logic [15:0] PPM_OPT_ACTUAL_POS       = 16'h0002;
	localparam int PPM_CW_NEW_SETPOINT = 4;
	localparam int PPM_CW_IMMEDIATE    = 5;
	localparam int PPM_CW_RELATIVE     = 6;
	localparam int PPM_CW_HALT         = 8;
	localparam int PPM_CW_CHANGE_ON_SP = 9;
	localparam int PPM_SW_TARGET       = 10;
	localparam int PPM_SW_SP_ACK       = 12;
	typedef enum logic [2:0] {
		PPM_IDLE = 3'b001,
		PPM_MOVE = 3'b010,
		PPM_STOP = 3'b100
	} ppm_state_t;
endpackage

// ### rtl/ppm_setpoint.sv
// One setpoint slot: holds target position, velocity, acceleration and deceleration.
// Assumes the caller gives a load strobe and already resolved absolute position.
`timescale 1ns/100ps
`default_nettype none
module ppm_setpoint #(
	parameter int W = 32
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// Load side
	input  wire logic         load,
	input  wire logic [W-1:0] pos_in,
	input  wire logic [W-1:0] vel_in,
	input  wire logic [W-1:0] acc_in,
	input  wire logic [W-1:0] dec_in,
	// Held setpoint
	output logic      [W-1:0] pos_out,
	output logic      [W-1:0] vel_out,
	output logic      [W-1:0] acc_out,
	output logic      [W-1:0] dec_out
);
	logic [4*W-1:0] set_reg;
	logic [4*W-1:0] set_next;

	always_comb begin
		set_next = set_reg;
		if (load) begin
			set_next = {pos_in, vel_in, acc_in, dec_in};
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			set_reg <= '0;
		end else begin
			set_reg <= set_next;
		end
	end

	assign {pos_out, vel_out, acc_out, dec_out} = set_reg;
endmodule
`default_nettype wire

// ### rtl/ppm_core.sv
// Profile position mode: parameter registers, control word decode, setpoint merging, status.
// Assumes an external profile generator that follows the active setpoint and reports
// reached and standstill, and a master that homes the axis before absolute moves.
//
// Contract
// - Writing the mode-select parameter activates the mode; motion starts only by control word.
// - Both merge bits 0, new-setpoint rising edge starts; later targets wait and axis stops.
// - Immediate bit 1: a rising edge starts a move and new targets take effect at once.
// - Control bit six 0 means absolute and 1 means relative positioning.
// - Status bit ten is target reached, or standstill while halt is active.
// - Status bit twelve is 1 once a new target was accepted, 0 when one may be supplied.
// - The mode ends only at standstill after target reached, halt, quick stop or error.
// - Merged target values are position, velocity, acceleration and deceleration.
// - Target position is signed 32-bit and written values take effect at the next setpoint load.
// - Target velocity is 1 to 4294967295, default 60, clamped to both maxima, next move.
// - Relative base 0 is previous target, 2 is actual position, 1 unsupported, next move.
`timescale 1ns/100ps
`default_nettype none
module ppm_core
#(
	parameter int W = 32
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// Parameter port
	input  wire logic              par_wr,
	input  wire logic              par_rd,
	input  wire logic [15:0]       par_addr,
	input  wire logic [31:0]       par_wdata,
	output logic      [31:0]       par_rdata,
	output logic                   par_err,
	// Control word and status word
	input  wire logic [15:0]       control_word,
	output logic      [15:0]       drive_status_word,
	// Profile generator side
	input  wire logic              gen_target_reached,
	input  wire logic              gen_standstill,
	input  wire logic              quick_stop,
	input  wire logic              error_stop,
	input  wire logic signed [W-1:0] actual_position,
	output logic                   mode_active,
	output logic                   move_enable,
	output logic signed [W-1:0]    active_position,
	output logic      [W-1:0]      active_velocity,
	output logic      [W-1:0]      active_accel,
	output logic      [W-1:0]      active_decel
);
	import ppm_pkg::*;
	if (W != 32) begin : g_width_check
		$error("ppm_core supports only 32-bit values");
	end

	logic [7:0]  mode_reg, mode_next;
	logic [31:0] tpos_reg, tpos_next, tvel_reg, tvel_next;
	logic [15:0] opt_reg, opt_next;
	logic [31:0] vmax_c_reg, vmax_c_next, vmax_r_reg, vmax_r_next;
	logic [31:0] acc_reg, acc_next, dec_reg, dec_next;
	logic        ns_reg, ns_next, ack_reg, ack_next, pend_reg, pend_next;
	logic        pend_rel_reg, pend_rel_next;
	logic        ended_reg, ended_next;
	ppm_state_t  state_reg, state_next;
	logic        sp_load, start_edge, cw_halt, in_mode;
	logic [31:0] vel_clamped, new_pos, rel_base;

	assign in_mode = (mode_reg == PPM_MODE_PROFILE_POS);
	assign cw_halt = control_word[PPM_CW_HALT];
	assign start_edge = in_mode && control_word[PPM_CW_NEW_SETPOINT] && !ns_reg;

	// Parameter writes
	always_comb begin
		mode_next = mode_reg;
		tpos_next = tpos_reg;
		tvel_next = tvel_reg;
		opt_next = opt_reg;
		vmax_c_next = vmax_c_reg;
		vmax_r_next = vmax_r_reg;
		acc_next = acc_reg;
		dec_next = dec_reg;
		if (par_wr) begin
			case (par_addr)
				PPM_ADDR_MODE_SELECT: mode_next = par_wdata[7:0];
				PPM_ADDR_TARGET_POSITION: tpos_next = par_wdata;
				PPM_ADDR_TARGET_VELOCITY: begin
					if (par_wdata >= PPM_TARGET_VEL_MIN) tvel_next = par_wdata;
				end
				PPM_ADDR_REL_REF_OPTION: begin
					if (par_wdata[15:0] == PPM_OPT_PREV_TARGET
						|| par_wdata[15:0] == PPM_OPT_ACTUAL_POS) begin
						opt_next = par_wdata[15:0];
					end
				end
				PPM_ADDR_VEL_LIMIT_CTRL: vmax_c_next = par_wdata;
				PPM_ADDR_VEL_LIMIT_RAMP: vmax_r_next = par_wdata;
				PPM_ADDR_ACCEL: acc_next = par_wdata;
				PPM_ADDR_DECEL: dec_next = par_wdata;
				default: ;
			endcase
		end
	end

	// Reads and access errors
	always_comb begin
		par_rdata = 32'h00000000;
		par_err = 1'b0;
		case (par_addr)
			PPM_ADDR_MODE_SELECT: par_rdata = {24'h000000, mode_reg};
			PPM_ADDR_TARGET_POSITION: par_rdata = tpos_reg;
			PPM_ADDR_TARGET_VELOCITY: par_rdata = tvel_reg;
			PPM_ADDR_REL_REF_OPTION: par_rdata = {16'h0000, opt_reg};
			PPM_ADDR_VEL_LIMIT_CTRL: par_rdata = vmax_c_reg;
			PPM_ADDR_VEL_LIMIT_RAMP: par_rdata = vmax_r_reg;
			PPM_ADDR_ACCEL: par_rdata = acc_reg;
			PPM_ADDR_DECEL: par_rdata = dec_reg;
			default: par_err = par_wr || par_rd;
		endcase
		if (par_wr && par_addr == PPM_ADDR_REL_REF_OPTION
			&& par_wdata[15:0] == PPM_OPT_UNSUPPORTED) begin
			par_err = 1'b1;
		end
	end

	always_comb begin
		vel_clamped = tvel_reg;
		if (vel_clamped > vmax_c_reg) vel_clamped = vmax_c_reg;
		if (vel_clamped > vmax_r_reg) vel_clamped = vmax_r_reg;
	end

	always_comb begin
		rel_base = (opt_reg == PPM_OPT_ACTUAL_POS) ? actual_position : active_position;
		new_pos = pend_rel_reg ? rel_base + tpos_reg : tpos_reg;
	end

	// Setpoint merging and move state
	always_comb begin
		state_next = state_reg;
		pend_next = pend_reg;
		pend_rel_next = pend_rel_reg;
		ack_next = ack_reg;
		ended_next = ended_reg;
		sp_load = 1'b0;
		ns_next = control_word[PPM_CW_NEW_SETPOINT];
		if (!control_word[PPM_CW_NEW_SETPOINT]) ack_next = 1'b0;
		if (start_edge) begin
			ack_next = 1'b1;
			pend_next = 1'b1;
			pend_rel_next = control_word[PPM_CW_RELATIVE];
		end
		case (state_reg)
			PPM_IDLE: begin
				if (pend_reg && !cw_halt) begin
					sp_load = 1'b1;
					pend_next = start_edge;
					ended_next = 1'b0;
					state_next = PPM_MOVE;
				end
			end
			PPM_MOVE: begin
				if (quick_stop || error_stop || cw_halt) begin
					state_next = PPM_STOP;
				end else if (pend_reg && control_word[PPM_CW_IMMEDIATE]) begin
					sp_load = 1'b1;
					pend_next = start_edge;
				end else if (pend_reg && gen_target_reached
					&& control_word[PPM_CW_CHANGE_ON_SP]) begin
					sp_load = 1'b1;
					pend_next = start_edge;
				end else if (gen_target_reached && gen_standstill) begin
					ended_next = 1'b1;
					state_next = PPM_IDLE;
				end
			end
			PPM_STOP: begin
				if (gen_standstill) begin
					ended_next = 1'b1;
					pend_next = start_edge;
					state_next = PPM_IDLE;
				end
			end
			default: state_next = PPM_IDLE;
		endcase
		if (!in_mode) begin
			state_next = PPM_IDLE;
			pend_next = 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			mode_reg <= 8'h00;
			tpos_reg <= 32'h00000000;
			tvel_reg <= PPM_TARGET_VEL_RESET;
			opt_reg <= PPM_OPT_PREV_TARGET;
			vmax_c_reg <= PPM_VEL_LIMIT_RESET;
			vmax_r_reg <= PPM_VEL_LIMIT_RESET;
			acc_reg <= PPM_ACCEL_RESET;
			dec_reg <= PPM_ACCEL_RESET;
			ns_reg <= 1'b0;
			ack_reg <= 1'b0;
			pend_reg <= 1'b0;
			pend_rel_reg <= 1'b0;
			ended_reg <= 1'b1;
			state_reg <= PPM_IDLE;
		end else begin
			mode_reg <= mode_next;
			tpos_reg <= tpos_next;
			tvel_reg <= tvel_next;
			opt_reg <= opt_next;
			vmax_c_reg <= vmax_c_next;
			vmax_r_reg <= vmax_r_next;
			acc_reg <= acc_next;
			dec_reg <= dec_next;
			ns_reg <= ns_next;
			ack_reg <= ack_next;
			pend_reg <= pend_next;
			pend_rel_reg <= pend_rel_next;
			ended_reg <= ended_next;
			state_reg <= state_next;
		end
	end

	ppm_setpoint #(
		.W(W)
	) u_setpoint (
		.clk    (clk),
		.reset  (reset),
		.load   (sp_load),
		.pos_in (new_pos),
		.vel_in (vel_clamped),
		.acc_in (acc_reg),
		.dec_in (dec_reg),
		.pos_out(active_position),
		.vel_out(active_velocity),
		.acc_out(active_accel),
		.dec_out(active_decel)
	);

	assign mode_active = in_mode;
	assign move_enable = (state_reg == PPM_MOVE);

	always_comb begin
		drive_status_word = 16'h0000;
		drive_status_word[PPM_SW_TARGET] = cw_halt ? gen_standstill
			: (ended_reg && gen_target_reached);
		drive_status_word[PPM_SW_SP_ACK] = ack_reg;
	end

	sequence start_seq;
		start_edge && !cw_halt && state_reg == PPM_IDLE;
	endsequence
	start_moves_a: assert property (@(posedge clk) disable iff (reset)
		start_seq |=> ##1 move_enable)
		else $error("move did not start after new setpoint edge");
	ack_set_a: assert property (@(posedge clk) disable iff (reset)
		start_edge |=> drive_status_word[PPM_SW_SP_ACK])
		else $error("setpoint acknowledge not raised");
	ack_clear_a: assert property (@(posedge clk) disable iff (reset)
		!control_word[PPM_CW_NEW_SETPOINT] |=> !drive_status_word[PPM_SW_SP_ACK])
		else $error("setpoint acknowledge not released");
	no_mode_idle_a: assert property (@(posedge clk) disable iff (reset)
		!in_mode |=> !move_enable)
		else $error("motion outside selected mode");
	immediate_take_a: assert property (@(posedge clk) disable iff (reset)
		(move_enable && pend_reg && control_word[PPM_CW_IMMEDIATE] && !cw_halt
		&& !quick_stop && !error_stop && in_mode) |-> sp_load)
		else $error("immediate setpoint not applied");
	stop_end_a: assert property (@(posedge clk) disable iff (reset)
		(state_reg == PPM_STOP && !gen_standstill) |=> state_reg != PPM_IDLE || !in_mode)
		else $error("mode ended before standstill");
	vel_clamp_a: assert property (@(posedge clk) disable iff (reset)
		sp_load |=> active_velocity <= $past(vmax_c_reg) && active_velocity <= $past(vmax_r_reg))
		else $error("velocity not clamped");
	halt_status_a: assert property (@(posedge clk) disable iff (reset)
		cw_halt |-> drive_status_word[PPM_SW_TARGET] == gen_standstill)
		else $error("status bit ten wrong under halt");
	option_one_a: assert property (@(posedge clk) disable iff (reset)
		opt_reg != PPM_OPT_UNSUPPORTED)
		else $error("unsupported relative option stored");
	abs_pos_a: assert property (@(posedge clk) disable iff (reset)
		(sp_load && !pend_rel_reg) |=> active_position == $past(tpos_reg))
		else $error("absolute target not loaded");
endmodule
`default_nettype wire

// ### bench/ppm_gen_model.sv
// Behavioural profile generator that follows the core's active setpoint.
// Assumes one clock; stop is the OR of halt, quick stop and error stop.
`timescale 1ns/100ps
`default_nettype none
module ppm_gen_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Setpoint side of the core
	input  wire logic        move_enable,
	input  wire logic [31:0] active_position,
	input  wire logic        stop,
	input  wire logic        slow,
	// Progress back to the core
	output logic             gen_target_reached,
	output logic             gen_standstill
);
	logic [7:0]  cnt;
	logic [1:0]  stop_cnt;
	logic [31:0] last_pos;
	logic        reached_reg;
	always_ff @(posedge clk) begin
		last_pos <= active_position;
		if (reset || !move_enable || active_position != last_pos) begin
			cnt <= 8'h00;
		end else if (cnt != 8'hFF) begin
			cnt <= cnt + 8'h01;
		end
		// Held after the move so status can still report it
		if (reset || active_position != last_pos) begin
			reached_reg <= 1'b0;
		end else if (cnt == (slow ? 8'h1E : 8'h04)) begin
			reached_reg <= 1'b1;
		end
		if (reset || !stop) begin
			stop_cnt <= 2'h0;
		end else if (stop_cnt != 2'h3) begin
			stop_cnt <= stop_cnt + 2'h1;
		end
	end
	// Stale flag masked the cycle a new setpoint shows up, else the move ends at once
	assign gen_target_reached = reached_reg && active_position == last_pos;
	assign gen_standstill = !move_enable || gen_target_reached || stop_cnt == 2'h3;
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the profile position core: registers, starts, merging, stops.
// Assumes the generator model stands at the core's setpoint outputs.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
	import ppm_pkg::*;
	logic               clk, reset, par_wr, par_rd, par_err, reached, still;
	logic               quick_stop, error_stop, mode_active, move_enable, slow;
	logic        [15:0] par_addr, cw, sw;
	logic        [31:0] par_wdata, par_rdata, avel, aacc, adec;
	logic signed [31:0] actual_position, apos;
	int                 errors, checks_done;
	ppm_core #(.W(32)) dut (.clk(clk), .reset(reset), .par_wr(par_wr), .par_rd(par_rd),
		.par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata), .par_err(par_err),
		.control_word(cw), .drive_status_word(sw), .gen_target_reached(reached),
		.gen_standstill(still), .quick_stop(quick_stop), .error_stop(error_stop),
		.actual_position(actual_position), .mode_active(mode_active),
		.move_enable(move_enable), .active_position(apos), .active_velocity(avel),
		.active_accel(aacc), .active_decel(adec));
	ppm_gen_model gen (.clk(clk), .reset(reset), .move_enable(move_enable),
		.active_position(apos), .stop(cw[8] | quick_stop | error_stop), .slow(slow),
		.gen_target_reached(reached), .gen_standstill(still));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic summarize();
		$display("checks=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		par_wr <= 1'b1;
		par_rd <= 1'b0;
		par_addr <= a;
		par_wdata <= d;
		@(posedge clk);
		par_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic e);
		@(posedge clk);
		par_rd <= 1'b1;
		par_addr <= a;
		@(negedge clk);
		`CHK(par_rdata, d)
		`CHK(par_err, e)
		@(posedge clk);
		par_rd <= 1'b0;
	endtask
	task automatic wme(input logic v, input int n);
		for (int k = 0; k < n && move_enable !== v; k++) @(negedge clk);
		`CHK(move_enable, v)
	endtask
	task automatic go(input logic rel, input logic imm);
		@(posedge clk);
		cw[4] <= 1'b1;
		cw[5] <= imm;
		cw[6] <= rel;
		for (int k = 0; k < 6 && sw[12] !== 1'b1; k++) @(negedge clk);
		`CHK(sw[12], 1'b1)
		@(posedge clk);
		cw[4] <= 1'b0;
		for (int k = 0; k < 6 && sw[12] !== 1'b0; k++) @(negedge clk);
		`CHK(sw[12], 1'b0)
	endtask
	task automatic t_regs();
		rd(PPM_ADDR_TARGET_VELOCITY, PPM_TARGET_VEL_RESET, 1'b0);
		rd(PPM_ADDR_REL_REF_OPTION, 32'h0, 1'b0);
		// Unmapped place reads zero and flags
		rd(16'h0000, 32'h0, 1'b1);
		wr(PPM_ADDR_TARGET_POSITION, 32'hFFFFFF9C);
		rd(PPM_ADDR_TARGET_POSITION, 32'hFFFFFF9C, 1'b0);
		wr(PPM_ADDR_TARGET_VELOCITY, 32'h0);
		rd(PPM_ADDR_TARGET_VELOCITY, PPM_TARGET_VEL_RESET, 1'b0);
		@(posedge clk);
		par_wr <= 1'b1;
		par_addr <= PPM_ADDR_REL_REF_OPTION;
		par_wdata <= 32'h1;
		@(negedge clk);
		`CHK(par_err, 1'b1)
		@(posedge clk);
		par_wr <= 1'b0;
		rd(PPM_ADDR_REL_REF_OPTION, 32'h0, 1'b0);
	endtask
	task automatic t_mode();
		@(posedge clk);
		cw[4] <= 1'b1;
		repeat (4) @(negedge clk);
		`CHK(move_enable, 1'b0)
		@(posedge clk);
		cw[4] <= 1'b0;
		wr(PPM_ADDR_MODE_SELECT, 32'h1);
		@(negedge clk);
		`CHK(mode_active, 1'b1)
		`CHK(move_enable, 1'b0)
	endtask
	task automatic t_abs();
		wr(PPM_ADDR_VEL_LIMIT_CTRL, 32'h32);
		wr(PPM_ADDR_TARGET_VELOCITY, 32'h3C);
		wr(PPM_ADDR_ACCEL, 32'h11);
		wr(PPM_ADDR_DECEL, 32'h22);
		wr(PPM_ADDR_TARGET_POSITION, 32'h64);
		// axis taken as homed at zero
		go(1'b0, 1'b0);
		wme(1'b1, 4);
		`CHK(apos, 32'sh64)
		`CHK(avel, 32'h32)
		`CHK(aacc, 32'h11)
		`CHK(adec, 32'h22)
		`CHK(sw[10], 1'b0)
		wme(1'b0, 20);
		`CHK(sw[10], 1'b1)
	endtask
	task automatic t_rel();
		wr(PPM_ADDR_TARGET_POSITION, 32'h5);
		go(1'b1, 1'b0);
		wme(1'b1, 4);
		`CHK(apos, 32'sh69)
		wme(1'b0, 20);
		wr(PPM_ADDR_REL_REF_OPTION, 32'h2);
		rd(PPM_ADDR_REL_REF_OPTION, 32'h2, 1'b0);
		@(posedge clk);
		actual_position <= 32'sh3E8;
		go(1'b1, 1'b0);
		wme(1'b1, 4);
		`CHK(apos, 32'sh3ED)
		wme(1'b0, 20);
	endtask
	task automatic t_imm();
		@(posedge clk);
		slow <= 1'b1;
		wr(PPM_ADDR_TARGET_POSITION, 32'h1F4);
		go(1'b0, 1'b0);
		wme(1'b1, 4);
		wr(PPM_ADDR_TARGET_POSITION, 32'h2BC);
		go(1'b0, 1'b1);
		`CHK(apos, 32'sh2BC)
		`CHK(move_enable, 1'b1)
		wme(1'b0, 80);
	endtask
	task automatic t_merge();
		int drops;
		// second target waits for the first
		wr(PPM_ADDR_TARGET_POSITION, 32'h300);
		go(1'b0, 1'b0);
		wr(PPM_ADDR_TARGET_POSITION, 32'h340);
		go(1'b0, 1'b0);
		`CHK(apos, 32'sh300)
		`CHK(move_enable, 1'b1)
		wme(1'b0, 60);
		`CHK(apos, 32'sh300)
		wme(1'b1, 4);
		`CHK(apos, 32'sh340)
		wme(1'b0, 60);
		@(posedge clk);
		cw[9] <= 1'b1;
		wr(PPM_ADDR_TARGET_POSITION, 32'h380);
		go(1'b0, 1'b0);
		wr(PPM_ADDR_TARGET_POSITION, 32'h3C0);
		go(1'b0, 1'b0);
		drops = 0;
		for (int k = 0; k < 60 && apos !== 32'sh3C0; k++) begin
			@(negedge clk);
			if (move_enable !== 1'b1) drops++;
		end
		`CHK(apos, 32'sh3C0)
		`CHK(drops, 0)
		wme(1'b0, 60);
		@(posedge clk);
		cw[9] <= 1'b0;
	endtask
	task automatic t_stop();
		for (int c = 0; c < 3; c++) begin
			wr(PPM_ADDR_TARGET_POSITION, 32'h100 + c);
			go(1'b0, 1'b0);
			wme(1'b1, 4);
			@(posedge clk);
			cw[8] <= (c == 0);
			quick_stop <= (c == 1);
			error_stop <= (c == 2);
			@(negedge clk);
			if (c == 0) `CHK(sw[10], 1'b0)
			wme(1'b0, 10);
			if (c == 0) `CHK(sw[10], 1'b1)
			@(posedge clk);
			{cw[8], quick_stop, error_stop} <= 3'b000;
		end
	endtask
	initial begin
		{reset, par_wr, par_rd, quick_stop, error_stop, slow} = 6'h20;
		{par_addr, cw, par_wdata, actual_position} = '0;
		{errors, checks_done} = '0;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		t_regs();
		t_mode();
		t_abs();
		t_rel();
		t_imm();
		t_merge();
		t_stop();
		summarize();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (3000) @(posedge clk);
		errors++;
		summarize();
	end
endmodule
`default_nettype wire
